// >>> pkg/adc_seq_pkg.sv
package adc_seq_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int         ADDR_W          = 3;
  localparam logic [2:0] ADDR_CTRL_ZERO  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO   = 3'h2;
  localparam logic [2:0] ADDR_RES_HIGH   = 3'h3;
  localparam logic [2:0] ADDR_RES_LOW    = 3'h4;
  localparam logic [2:0] ADDR_STATUS     = 3'h5;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int GO_BIT     = 1;
  localparam int CHAN_LSB   = 2;
  localparam int CLK_LSB    = 0;
  localparam int ACQ_LSB    = 3;
  localparam int FMT_BIT    = 7;
  localparam int FLAG_BIT   = 0;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [3:0]  NIB_ZERO   = 4'h0;
  localparam logic [11:0] SAR_FIRST  = 12'h800;
  localparam logic [11:0] SAR_ZERO   = 12'h000;
  localparam logic [1:0]  CLK_RC     = 2'h3;
  localparam logic [2:0]  ACQ_MANUAL = 3'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCY_NS        = 40;
  localparam int TCY_CYCLES    = TCY_NS / CLK_PERIOD_NS;
  localparam int WAIT_TCY      = 2;
  localparam int WAIT_CYCLES   = WAIT_TCY * TCY_CYCLES;
  localparam logic [4:0] CONV_LAST_TAD = 5'h0C;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011,
    ST_WAIT  = 3'b100
  } conv_state_e;

  // acquisition length in converter clock periods
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h7:    acq_tads = 5'h14;
      3'h6:    acq_tads = 5'h10;
      3'h5:    acq_tads = 5'h0C;
      3'h4:    acq_tads = 5'h08;
      3'h3:    acq_tads = 5'h06;
      3'h2:    acq_tads = 5'h04;
      3'h1:    acq_tads = 5'h02;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  // last count of the system clock divider
  function automatic logic [5:0] div_last(input logic [2:0] code);
    case (code)
      3'h0:    div_last = 6'h01;
      3'h4:    div_last = 6'h03;
      3'h1:    div_last = 6'h07;
      3'h5:    div_last = 6'h0F;
      3'h2:    div_last = 6'h1F;
      3'h6:    div_last = 6'h3F;
      default: div_last = 6'h01;
    endcase
  endfunction

endpackage

// >>> rtl/adc_sequencer_control.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1 - successive approximation yields 12-bit result
// R2 - channel field bits 5:2 picks input
// R3 - codes 1100-1111 absent on small variant; the channel field still takes all 16 codes when NUM_CHANNELS is 12
// R4 - status bit reads 1 while converting
// R5 - enable bit switches converter on/off
// R6 - format bit: 1 right, 0 left justified
// R7 - acquisition code maps to 0..20 periods
// R8 - clock field selects divisor or RC
// R9 - RC clock waits one instruction cycle
// R10 - in sleep only RC clock runs
// R11 - reset clears registers, aborts conversion
// R12 - completion: store result, clear status, flag
// R13 - programmed acquisition then automatic conversion
// R14 - code 000 converts immediately
// R15 - sampling resumes after each conversion
// R16 - no acquisition-end indication; status stays set
// R17 - software waits acquisition in manual mode
// R18 - hold capacitor disconnected during conversion
// R19 - unused bits ignore writes, read zero
// R20 - clearing status aborts, result kept
// R21 - two instruction cycles before resampling
// R22 - conversion takes thirteen converter clocks
// R23 - status set while disabled does nothing
module adc_sequencer_control
  import adc_seq_pkg::*;
#(
  parameter int NUM_CHANNELS = 16
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // register port
  input  wire logic [adc_seq_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr_strobe,
  input  wire logic                       rd_strobe,
  output logic      [7:0]                 rdata,
  // device state
  input  wire logic                       device_sleep,
  input  wire logic                       internal_rc_clock,
  // analog front end
  input  wire logic                       comparator_high,
  output logic      [3:0]                 channel_select,
  output logic                            sample_connect,
  output logic      [11:0]                trial_code,
  output logic                            converter_interrupt_flag
);
  import adc_seq_pkg::*;

  // --------------------------------------------------
  // elaboration check
  // --------------------------------------------------
  // R3
  if (NUM_CHANNELS != 12 && NUM_CHANNELS != 16) begin : g_chk
    $error("NUM_CHANNELS must be 12 or 16");
  end

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  typedef struct packed {
    logic        rc_s1;
    logic        rc_s2;
    logic        rc_prev;
    logic        enable;
    logic        go;
    logic [3:0]  channel;
    logic        fmt;
    logic [2:0]  acq;
    logic [2:0]  clksel;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;
    logic        flag;
    conv_state_e st;
    logic [5:0]  div_cnt;
    logic [4:0]  tad_cnt;
    logic [3:0]  cyc_cnt;
    logic [11:0] sar;
    logic [7:0]  rd;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic       rc_mode;
  logic       tick;
  logic       done;
  logic       wr_ctrl0;
  logic [3:0] bit_idx;

  // R8 R10
  assign rc_mode = (state_reg.clksel[1:0] == CLK_RC);
  assign tick    = rc_mode ? (state_reg.rc_s2 & ~state_reg.rc_prev)
                           : (~device_sleep &&
                              state_reg.div_cnt == div_last(state_reg.clksel));
  // R22
  assign done     = (state_reg.st == ST_CONV) && tick &&
                    (state_reg.tad_cnt == CONV_LAST_TAD);
  assign wr_ctrl0 = wr_strobe && (addr == ADDR_CTRL_ZERO);
  assign bit_idx  = 4'(CONV_LAST_TAD - state_reg.tad_cnt);

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // synchronisers
    state_next.rc_s1   = internal_rc_clock;
    state_next.rc_s2   = state_reg.rc_s1;
    state_next.rc_prev = state_reg.rc_s2;

    // divider runs only while timing a phase
    if (state_reg.st == ST_ACQ || state_reg.st == ST_CONV) begin
      state_next.div_cnt = (tick || rc_mode) ? 6'h00
                                             : state_reg.div_cnt + 6'h01;
    end else begin
      state_next.div_cnt = 6'h00;
    end

    // sequencer
    case (state_reg.st)
      ST_IDLE: begin
        if (state_reg.go) begin
          state_next.cyc_cnt = 4'h0;
          state_next.tad_cnt = 5'h00;
          state_next.sar     = SAR_FIRST;
          if (rc_mode) begin
            state_next.st = ST_DELAY; // R9
          end else if (state_reg.acq == ACQ_MANUAL) begin
            state_next.st = ST_CONV; // R14
          end else begin
            state_next.st = ST_ACQ; // R13
          end
        end
      end
      ST_DELAY: begin
        state_next.cyc_cnt = state_reg.cyc_cnt + 4'h1;
        if (state_reg.cyc_cnt == 4'(TCY_CYCLES - 1)) begin
          state_next.st = (state_reg.acq == ACQ_MANUAL) ? ST_CONV
                                                        : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (tick) begin
          state_next.tad_cnt = state_reg.tad_cnt + 5'h01;
          // R7 R13
          if (state_reg.tad_cnt + 5'h01 >= acq_tads(state_reg.acq)) begin
            state_next.st      = ST_CONV;
            state_next.tad_cnt = 5'h00;
          end
        end
      end
      ST_CONV: begin
        // first period lets the hold settle, then one bit per period
        if (tick) begin
          state_next.tad_cnt = state_reg.tad_cnt + 5'h01;
          if (state_reg.tad_cnt != 5'h00) begin
            // R1 comparator answers our own registered trial word, so
            // no synchroniser: two flops would miss a two-clock period
            if (!comparator_high) begin
              state_next.sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              state_next.sar[bit_idx - 4'h1] = 1'b1;
            end
          end
        end
        if (done) begin
          // R12 R6
          if (state_reg.fmt) begin
            state_next.res_hi = {NIB_ZERO, state_next.sar[11:8]};
            state_next.res_lo = state_next.sar[7:0];
          end else begin
            state_next.res_hi = state_next.sar[11:4];
            state_next.res_lo = {state_next.sar[3:0], NIB_ZERO};
          end
          state_next.go      = 1'b0;
          state_next.st      = ST_WAIT;
          state_next.cyc_cnt = 4'h0;
        end
      end
      ST_WAIT: begin
        // R21 R15
        state_next.cyc_cnt = state_reg.cyc_cnt + 4'h1;
        if (state_reg.cyc_cnt == 4'(WAIT_CYCLES - 1)) begin
          state_next.st = ST_IDLE;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase

    // R12 hardware set beats software clear
    if (done) begin
      state_next.flag = 1'b1;
    end else if (wr_strobe && addr == ADDR_STATUS && wdata[FLAG_BIT]) begin
      state_next.flag = 1'b0;
    end

    // register writes, unused bits dropped (R19)
    if (wr_strobe) begin
      case (addr)
        ADDR_CTRL_ZERO: begin
          state_next.channel = wdata[CHAN_LSB +: 4]; // R2
          state_next.enable  = wdata[ENABLE_BIT]; // R5
          // R23: only an already running module accepts a start
          if (wdata[GO_BIT] && state_reg.enable && wdata[ENABLE_BIT]) begin
            state_next.go = 1'b1;
          end else if (!wdata[GO_BIT]) begin
            state_next.go = 1'b0;
            // R20 abort, result untouched
            if (state_reg.st == ST_DELAY || state_reg.st == ST_ACQ ||
                state_reg.st == ST_CONV) begin
              state_next.st      = ST_WAIT;
              state_next.cyc_cnt = 4'h0;
              state_next.res_hi  = state_reg.res_hi;
              state_next.res_lo  = state_reg.res_lo;
              state_next.flag    = state_reg.flag; // abort beats completion
            end
          end
        end
        ADDR_CTRL_TWO: begin
          state_next.fmt    = wdata[FMT_BIT];
          state_next.acq    = wdata[ACQ_LSB +: 3];
          state_next.clksel = wdata[CLK_LSB +: 3];
        end
        ADDR_RES_HIGH: begin
          state_next.res_hi = wdata;
        end
        ADDR_RES_LOW: begin
          state_next.res_lo = wdata;
        end
        default: begin
        end
      endcase
    end

    // R5 switched off: everything stops at once
    if (!state_next.enable) begin
      state_next.go = 1'b0;
      state_next.st = ST_IDLE;
    end

    // read data, one cycle after the strobe
    state_next.rd = BYTE_ZERO;
    if (rd_strobe) begin
      case (addr)
        ADDR_CTRL_ZERO: begin
          state_next.rd = {2'h0, state_reg.channel, state_reg.go,
                           state_reg.enable}; // R19 R4
        end
        ADDR_CTRL_TWO: begin
          state_next.rd = {state_reg.fmt, 1'b0, state_reg.acq,
                           state_reg.clksel}; // R19
        end
        ADDR_RES_HIGH: begin
          state_next.rd = state_reg.res_hi;
        end
        ADDR_RES_LOW: begin
          state_next.rd = state_reg.res_lo;
        end
        ADDR_STATUS: begin
          state_next.rd = {7'h00, state_reg.flag};
        end
        default: begin
          state_next.rd = BYTE_ZERO;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  // R11
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign rdata                    = state_reg.rd;
  assign channel_select           = state_reg.channel;
  assign trial_code               = state_reg.sar;
  assign converter_interrupt_flag = state_reg.flag;
  // R18 R14: manual mode stops sampling as soon as a start is seen
  assign sample_connect = state_reg.enable &&
                          ((state_reg.st == ST_IDLE &&
                            !(state_reg.go && state_reg.acq == ACQ_MANUAL)) ||
                           state_reg.st == ST_ACQ ||
                           (state_reg.st == ST_DELAY &&
                            state_reg.acq != ACQ_MANUAL));

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  flag_on_done_a: assert property ( // R12
    done && !wr_ctrl0 |=>
      state_reg.flag && !state_reg.go && state_reg.st == ST_WAIT)
    else $error("completion did not flag and clear status");

  right_just_a: assert property ( // R6
    done && state_reg.fmt |=> state_reg.res_hi[7:4] == NIB_ZERO)
    else $error("right justified result has high bits set");

  busy_status_a: assert property ( // R4 R16
    (state_reg.st == ST_ACQ || state_reg.st == ST_CONV ||
     state_reg.st == ST_DELAY) |-> state_reg.go)
    else $error("status bit low while busy");

  off_idle_a: assert property ( // R5
    !state_reg.enable |-> state_reg.st == ST_IDLE && !state_reg.go)
    else $error("disabled converter not idle");

  hold_open_a: assert property ( // R18
    state_reg.st == ST_CONV |-> !sample_connect)
    else $error("hold capacitor connected while converting");

  resample_wait_a: assert property ( // R21
    $rose(state_reg.st == ST_WAIT) |->
      (state_reg.st == ST_WAIT || !state_reg.enable)[*8])
    else $error("resampling started early");

  rc_delay_a: assert property ( // R9
    state_reg.st == ST_IDLE && state_reg.go && rc_mode |=>
      state_reg.st == ST_DELAY || !state_reg.enable)
    else $error("rc start skipped delay");

  manual_start_a: assert property ( // R14
    state_reg.st == ST_IDLE && state_reg.go && !rc_mode &&
    state_reg.acq == ACQ_MANUAL && !wr_ctrl0 |=> state_reg.st == ST_CONV)
    else $error("manual start not immediate");

  abort_keep_a: assert property ( // R20
    state_reg.st == ST_CONV && wr_ctrl0 && !wdata[GO_BIT] &&
    wdata[ENABLE_BIT] |=> state_reg.st == ST_WAIT &&
      $stable(state_reg.res_hi) && $stable(state_reg.res_lo))
    else $error("abort changed result");

  sleep_hold_a: assert property ( // R10
    state_reg.st == ST_CONV && device_sleep && !rc_mode && !wr_strobe |=>
      $stable(state_reg.sar))
    else $error("conversion ran in sleep without rc clock");

  unused_zero_a: assert property ( // R19
    rd_strobe && addr == ADDR_CTRL_ZERO |=> rdata[7:6] == 2'h0)
    else $error("unused bits read nonzero");

  manual_conv_c: cover property (
    state_reg.st == ST_IDLE && state_reg.go && state_reg.acq == ACQ_MANUAL);
  auto_acq_c: cover property (
    state_reg.st == ST_ACQ ##[1:1000] done);
  abort_c: cover property (
    state_reg.st == ST_CONV && wr_ctrl0 && !wdata[GO_BIT]);

endmodule

`default_nettype wire

// >>> tb/adc_sequencer_control_test.sv
`timescale 1ns/100ps
`default_nettype none

module adc_sequencer_control_test;
  import adc_seq_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [7:0]        wdata = 8'h00;
  logic              wr_strobe = 1'b0;
  logic              rd_strobe = 1'b0;
  logic              device_sleep = 1'b0;
  logic              internal_rc_clock = 1'b0;
  logic [7:0]        rdata;
  logic              comparator_high;
  logic [3:0]        channel_select;
  logic              sample_connect;
  logic [11:0]       trial_code;
  logic              converter_interrupt_flag;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                acq_len [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int                div_len [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  // ctrl two, channel, expected result high, result low
  logic [27:0]       rows [8] = '{
    28'h00_0_0F_50, 28'h88_3_03_C6, 28'h11_5_5A_00, 28'h9A_7_07_82,
    28'h24_9_96_C0, 28'hAD_C_0C_39, 28'h36_E_E1_B0, 28'hBB_F_0F_0A};

  always #5 mclk = ~mclk;
  // rc oscillator free running, far slower than mclk
  always #500 internal_rc_clock = ~internal_rc_clock;

  adc_sequencer_control #(
    .NUM_CHANNELS(16)
  ) adc_sequencer_control_i (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .device_sleep(device_sleep), .internal_rc_clock(internal_rc_clock),
    .comparator_high(comparator_high), .channel_select(channel_select),
    .sample_connect(sample_connect), .trial_code(trial_code),
    .converter_interrupt_flag(converter_interrupt_flag)
  );

  analog_front_model analog_front_model_i (
    .mclk(mclk), .channel_select(channel_select),
    .sample_connect(sample_connect), .trial_code(trial_code),
    .comparator_high(comparator_high)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge mclk);
    wr_strobe <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] want);
    @(posedge mclk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge mclk);
    rd_strobe <= 1'b0;
    #1 check(20'(rdata), 20'(want));
  endtask

  // channel first, settle, then go with enable already on
  task automatic start(input logic [7:0] c2, input logic [3:0] ch);
    wr(ADDR_CTRL_TWO, c2);
    wr(ADDR_CTRL_ZERO, {2'b00, ch, 2'b01});
    repeat (40) @(posedge mclk);
    wr(ADDR_CTRL_ZERO, {2'b00, ch, 2'b11});
  endtask

  task automatic wait_flag(output int n);
    n = 0;
    while (converter_interrupt_flag !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 8000) begin
        n_errors++;
        final_report();
      end
    end
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #600000;
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0] c2;
    logic [3:0] ch;
    logic [7:0] hi;
    logic [7:0] lo;
    int         n;
    int         t;
    int         dv;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    #1;
    for (int a = 0; a < 8; a++) begin
      rd_chk(3'(a), 8'h00);
    end
    check(20'({sample_connect, converter_interrupt_flag, trial_code}), 20'h0);
    wr(ADDR_CTRL_ZERO, 8'hC3);
    rd_chk(ADDR_CTRL_ZERO, 8'h01);
    wr(ADDR_CTRL_TWO, 8'h40);
    rd_chk(ADDR_CTRL_TWO, 8'h00);
    wr(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00);
    check(20'({sample_connect, converter_interrupt_flag}), 20'h2);
    foreach (rows[i]) begin
      {c2, ch, hi, lo} = rows[i];
      dv = div_len[c2[2:0]];
      t = (acq_len[c2[5:3]] + 13) * dv;
      start(c2, ch);
      #1 check(20'(channel_select), 20'(ch));
      if (dv != 0) check(20'(sample_connect), 20'(|c2[5:3]));
      rd_chk(ADDR_CTRL_ZERO, {2'b00, ch, 2'b11});
      wait_flag(n);
      n += 2 - t;
      // divider starts each phase from zero, so the first period runs full length
      if (dv != 0) check(20'(n >= -dv && n <= dv + 8), 20'h1);
      check(20'(sample_connect), 20'h0);
      rd_chk(ADDR_CTRL_ZERO, {2'b00, ch, 2'b01});
      rd_chk(ADDR_CTRL_TWO, c2);
      rd_chk(ADDR_RES_HIGH, hi);
      rd_chk(ADDR_RES_LOW, lo);
      rd_chk(ADDR_STATUS, 8'h01);
      repeat (2) @(posedge mclk);
      #1 check(20'(sample_connect), 20'h1);
      wr(ADDR_STATUS, 8'h01);
      #1 check(20'(converter_interrupt_flag), 20'h0);
    end
    // abort in mid conversion keeps the earlier result
    start(8'h86, 4'h5);
    repeat (300) @(posedge mclk);
    wr(ADDR_CTRL_ZERO, 8'h15);
    repeat (900) @(posedge mclk);
    #1 check(20'({sample_connect, converter_interrupt_flag}), 20'h2);
    rd_chk(ADDR_RES_HIGH, 8'h0F);
    rd_chk(ADDR_RES_LOW, 8'h0A);
    // software may load the result pair directly
    wr(ADDR_RES_HIGH, 8'hA5);
    wr(ADDR_RES_LOW, 8'h5A);
    rd_chk(ADDR_RES_HIGH, 8'hA5);
    rd_chk(ADDR_RES_LOW, 8'h5A);
    // in sleep only the rc clock may finish a conversion
    @(posedge mclk);
    device_sleep <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      start(k ? 8'h83 : 8'h80, 4'h3);
      repeat (2000) @(posedge mclk);
      #1 check(20'(converter_interrupt_flag), 20'(k));
      wr(ADDR_STATUS, 8'h01);
      wr(ADDR_CTRL_ZERO, 8'h0D);
    end
    device_sleep <= 1'b0;
    start(8'h86, 4'h9);
    repeat (300) @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    #1 check(20'({channel_select, sample_connect, trial_code}), 20'h0);
    check(20'(converter_interrupt_flag), 20'h0);
    rd_chk(ADDR_CTRL_ZERO, 8'h00);
    rd_chk(ADDR_CTRL_TWO, 8'h00);
    rd_chk(ADDR_RES_LOW, 8'h00);
    final_report();
  end
endmodule

`default_nettype wire

// >>> tb/analog_front_model.sv
`timescale 1ns/100ps
`default_nettype none

module analog_front_model (
  // clock
  input  wire logic        mclk,
  // converter side
  input  wire logic [3:0]  channel_select,
  input  wire logic        sample_connect,
  input  wire logic [11:0] trial_code,
  output logic             comparator_high
);
  // ----------------------------------------
  // hold capacitor and comparator
  // ----------------------------------------
  logic [11:0] held_reg;

  // fixed pin level per channel, distinct in every nibble
  function automatic logic [11:0] level(input logic [3:0] c);
    return {c, ~c, c ^ 4'h5};
  endfunction

  // cap tracks the pin only while connected; left alone it holds
  always_ff @(posedge mclk) begin
    if (sample_connect) begin
      held_reg <= level(channel_select);
    end
  end

  assign comparator_high = (held_reg >= trial_code);
endmodule

`default_nettype wire
